// *** adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

	// ------------------------------------------------------------------
	// Register offsets and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] CONV_TIME_CH0_OFS = 8'h30;
	localparam logic [7:0] CONV_TIME_CH1_OFS = 8'h32;
	localparam logic [7:0] MODE_RD_OFS       = 8'h38;
	localparam logic [7:0] MODE_WR_ALT_OFS   = 8'h3A;
	localparam logic [7:0] CONV_TIME_RST     = 8'h91;
	localparam logic [7:0] MODE_RST          = 8'h00;
	// Address bit that names the channel of a mode write.
	localparam int         CHAN_ADDR_BIT     = 1;

	// ------------------------------------------------------------------
	// Conversion length formula terms, in master clock cycles, and synchroniser depth
	// ------------------------------------------------------------------
	localparam logic [14:0] ALT_ON_STEP   = 15'h0080;
	localparam logic [14:0] ALT_ON_BASE   = 15'h00F8;
	localparam logic [14:0] ALT_OFF_STEP  = 15'h0040;
	localparam logic [14:0] ALT_OFF_BASE  = 15'h00CE;
	localparam logic [14:0] TWO_CHAN_XTRA = 15'h0001;
	localparam int          SYNC_STAGES   = 3;

	// ------------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_IDLE, OP_CONTINUOUS, OP_SINGLE, OP_STANDBY,
		OP_SELF_ZERO, OP_RESERVED, OP_SYS_ZERO, OP_SYS_FULL
	} operation_select_t;

	typedef struct packed {
		logic       offset_alternation_enable;
		logic [6:0] filter_length_word;
	} conv_time_t;

	typedef struct packed {
		operation_select_t operation_select;
		logic              clock_output_off;
		logic              dump;
		logic              continuous_read;
		logic              wide_result;
		logic              clamp;
	} mode_reg_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_CONVERT, ST_STANDBY
	} ctrl_fsm_t;

	typedef struct packed {
		logic             wr_en;
		logic             rd_en;
		logic [7:0]       addr;
		logic [7:0]       wdata;
	} reg_req_t;

	typedef struct packed {
		conv_time_t [1:0] conv_time;
		mode_reg_t        mode;
		logic             chan;
		ctrl_fsm_t        fsm;
		logic [14:0]      count;
		logic             done_n;
		logic [7:0]       rdata;
		logic [23:0]      result;
		logic             result_chan;
		logic             result_stb;
		logic             cal_done_stb;
		logic             status_clr_stb;
		logic [SYNC_STAGES-1:0] ext_sync;
		logic             ext_clk;
	} ctrl_state_t;

endpackage

// *** adc_mode_and_timing_control.sv ***
`timescale 1ns/1ps
// Functional notes
// R1: Two 8-bit RW conversion time registers at 30h and 32h, reset 91h.
// R2: Bit 7 enables offset alternation; bits 6..0 are the filter word.
// R3: Alternation on, single or one channel: word*128+248 cycles, word 2..127.
// R4: Alternation on, two channels continuous: word*128+249 cycles.
// R5: Alternation off, single or one channel: word*64+206 cycles, word 3..127.
// R6: Alternation off, two channels continuous: word*64+207 cycles.
// R7: One 8-bit RW mode register, reset 00h, written at 38h or 3Ah.
// R8: Mode write clears status, raises done pin, aborts, starts new mode.
// R9: Address bit 1 of a mode write picks the channel used.
// R10: Host reads the mode register only at 38h.
// R11: A new operation code leaves the old mode and enters the new at once.
// R12: Codes: idle, continuous, single, standby, self zero, reserved, sys cals.
// R13: Written channel is first converted, converted, timed or calibrated.
// R14: Clock-output-off bit floats the oscillator drive pin.
// R15: Clock output off with crystal source stops conversions.
// R16: Dump bit makes a status or data read return status then data.
// R17: Continuous read bit always delivers status then data.
// R18: Width bit selects 24-bit results when set, 16-bit when clear.
// R19: Clamp bit saturates out-of-range results to all zeros or all ones.
// R20: Idle after reset; idle again after any calibration or single conversion.
// R21: Continuous mode posts each result, then moves to the next enabled channel.
// R22: Single conversion end drops done pin, clears operation code, goes idle.
// R23: Length counter follows the formula and reloads at every conversion start.
module adc_mode_and_timing_control
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic [1:0]  chan_enable_i,
	input  wire logic        ext_clock_source_i,
	input  wire logic [23:0] sample_i,
	input  wire logic        over_range_i,
	input  wire logic        negative_i,
	output logic             conv_done_n_o,
	output logic             status_clear_o,
	output logic             result_valid_o,
	output logic      [23:0] result_data_o,
	output logic             result_chan_o,
	output logic             cal_done_o,
	output logic             converting_o,
	output logic             active_chan_o,
	output logic      [2:0]  operation_select_o,
	output logic             standby_o,
	output logic             oscillator_drive_oe_o,
	output logic             converter_clock_run_o,
	output logic             status_with_data_o,
	output logic             continuous_read_o,
	output logic             wide_result_o
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Conversion length in master clock cycles for one channel setting.
	function automatic logic [14:0] conv_cycles(input conv_time_t ct,
			input logic two_chan);
		logic [14:0] fw;
		logic [14:0] len;
		fw = {8'h00, ct.filter_length_word};
		// R2: alternation select
		if (ct.offset_alternation_enable) begin
			// R3: alternation on length
			len = 15'(fw * ALT_ON_STEP) + ALT_ON_BASE;
		end else begin
			// R5: alternation off length
			len = 15'(fw * ALT_OFF_STEP) + ALT_OFF_BASE;
		end
		// R6: two channel extra
		if (two_chan) begin
			len = len + TWO_CHAN_XTRA;
		end
		return len;
	endfunction

	// Clamped or raw result, as the clamp bit asks.
	function automatic logic [23:0] shape_result(input logic [23:0] raw,
			input logic clamp, input logic over, input logic neg);
		// R19: clamp saturation
		if (clamp && over) begin
			return neg ? 24'h000000 : 24'hFFFFFF;
		end
		return raw;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	ctrl_state_t s_q;
	ctrl_state_t s_d;
	reg_req_t    req;
	logic        mode_wr;
	logic        clk_stopped;
	logic        two_chan;
	logic        end_conv;
	logic        next_chan;
	logic [14:0] load_len;

	assign req = '{wr_en: reg_wr_i, rd_en: reg_rd_i,
		addr: reg_addr_i, wdata: reg_wdata_i};

	// Both offsets reach the one mode register.
	// R7: mode write decode
	assign mode_wr = req.wr_en && (req.addr == MODE_RD_OFS ||
		req.addr == MODE_WR_ALT_OFS);

	// A crystal needs our drive; cutting it stops the converter clock.
	// R15: crystal stop condition
	assign clk_stopped = s_q.mode.clock_output_off && !s_q.ext_clk;
	// R4: two channel extra cycle
	assign two_chan = (s_q.mode.operation_select == OP_CONTINUOUS) &&
		(&chan_enable_i);
	assign end_conv = (s_q.fsm == ST_CONVERT) && !clk_stopped &&
		(s_q.count == 15'h0000);
	// R21: next enabled channel
	assign next_chan = chan_enable_i[~s_q.chan] ? ~s_q.chan : s_q.chan;
	// R23: reload length
	assign load_len = conv_cycles(s_q.conv_time[next_chan], two_chan) -
		15'h0001;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// The strobes default low so each lives exactly one cycle.
	always_comb begin
		s_d = s_q;
		s_d.result_stb = 1'b0;
		s_d.cal_done_stb = 1'b0;
		s_d.status_clr_stb = 1'b0;
		// Pin synchroniser; only the last two stages are compared.
		s_d.ext_sync = {s_q.ext_sync[SYNC_STAGES-2:0], ext_clock_source_i};
		if (s_q.ext_sync[SYNC_STAGES-1] == s_q.ext_sync[SYNC_STAGES-2]) begin
			s_d.ext_clk = s_q.ext_sync[SYNC_STAGES-1];
		end

		// Register reads; 3Ah and unmapped offsets read as zero.
		// R10: read only at 38h
		if (req.rd_en) begin
			case (req.addr)
				CONV_TIME_CH0_OFS: s_d.rdata = s_q.conv_time[0];
				CONV_TIME_CH1_OFS: s_d.rdata = s_q.conv_time[1];
				MODE_RD_OFS:       s_d.rdata = s_q.mode;
				default:           s_d.rdata = 8'h00;
			endcase
		end

		// R1: conversion time writes
		if (req.wr_en && req.addr == CONV_TIME_CH0_OFS) begin
			s_d.conv_time[0] = req.wdata;
		end
		if (req.wr_en && req.addr == CONV_TIME_CH1_OFS) begin
			s_d.conv_time[1] = req.wdata;
		end

		// Conversion progress; the counter holds while the clock is stopped.
		if (s_q.fsm == ST_CONVERT && !clk_stopped && !end_conv) begin
			s_d.count = s_q.count - 15'h0001;
		end
		if (end_conv) begin
			case (s_q.mode.operation_select)
				// R21: post and move on
				OP_CONTINUOUS: begin
					s_d.result_stb = 1'b1;
					s_d.done_n = 1'b0;
					s_d.chan = next_chan;
					s_d.count = load_len;
				end
				// R22: single conversion end
				OP_SINGLE: begin
					s_d.result_stb = 1'b1;
					s_d.done_n = 1'b0;
					s_d.mode.operation_select = OP_IDLE;
					s_d.fsm = ST_IDLE;
				end
				// R20: calibrations return to idle
				default: begin
					s_d.cal_done_stb = 1'b1;
					s_d.mode.operation_select = OP_IDLE;
					s_d.fsm = ST_IDLE;
				end
			endcase
			if (s_q.mode.operation_select inside {OP_CONTINUOUS, OP_SINGLE})
					begin
				s_d.result = shape_result(sample_i, s_q.mode.clamp,
					over_range_i, negative_i);
				s_d.result_chan = s_q.chan;
			end
		end

		// A mode write wins over a finishing conversion: it aborts it.
		// R8: abort and restart
		if (mode_wr) begin
			s_d.mode = req.wdata;
			// R9: channel from address
			s_d.chan = req.addr[CHAN_ADDR_BIT];
			s_d.done_n = 1'b1;
			s_d.status_clr_stb = 1'b1;
			s_d.result_stb = 1'b0;
			s_d.cal_done_stb = 1'b0;
			// R12: operation decode
			// R11: immediate mode entry
			case (operation_select_t'(req.wdata[7:5]))
				OP_CONTINUOUS, OP_SINGLE, OP_SELF_ZERO,
				OP_SYS_ZERO, OP_SYS_FULL: begin
					s_d.fsm = ST_CONVERT;
				end
				OP_STANDBY: s_d.fsm = ST_STANDBY;
				default:    s_d.fsm = ST_IDLE;
			endcase
			// R13: channel sets the length
			s_d.count = conv_cycles(s_q.conv_time[req.addr[CHAN_ADDR_BIT]],
				(operation_select_t'(req.wdata[7:5]) == OP_CONTINUOUS) &&
				(&chan_enable_i)) - 15'h0001;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// R20: idle after reset
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
			s_q.conv_time[0] <= CONV_TIME_RST;
			s_q.conv_time[1] <= CONV_TIME_RST;
			s_q.mode <= MODE_RST;
			s_q.fsm <= ST_IDLE;
			s_q.done_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o = s_q.rdata;
	assign conv_done_n_o = s_q.done_n;
	assign status_clear_o = s_q.status_clr_stb;
	assign result_valid_o = s_q.result_stb;
	assign result_data_o = s_q.result;
	assign result_chan_o = s_q.result_chan;
	assign cal_done_o = s_q.cal_done_stb;
	assign converting_o = (s_q.fsm == ST_CONVERT) && !clk_stopped;
	assign active_chan_o = s_q.chan;
	assign operation_select_o = s_q.mode.operation_select;
	assign standby_o = (s_q.fsm == ST_STANDBY);
	// R14: drive pin floats
	assign oscillator_drive_oe_o = !s_q.mode.clock_output_off;
	assign converter_clock_run_o = !clk_stopped;
	// R16: dump read
	// R17: continuous read dump
	assign status_with_data_o = s_q.mode.dump || s_q.mode.continuous_read;
	assign continuous_read_o = s_q.mode.continuous_read;
	// R18: result width
	assign wide_result_o = s_q.mode.wide_result;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	mode_wr_done_a: assert property (@(posedge clk_sys_i) // R8
		disable iff (!rstn_i) mode_wr |=> conv_done_n_o && status_clear_o)
		else $error("mode write did not raise done pin");
	mode_wr_chan_a: assert property (@(posedge clk_sys_i) // R9
		disable iff (!rstn_i)
		mode_wr |=> active_chan_o == $past(reg_addr_i[1]))
		else $error("mode write channel wrong");
	mode_enter_a: assert property (@(posedge clk_sys_i) // R11
		disable iff (!rstn_i) mode_wr && reg_wdata_i[7:5] == 3'h2
		|=> converting_o || !converter_clock_run_o)
		else $error("single mode not entered");
	single_end_a: assert property (@(posedge clk_sys_i) // R22
		disable iff (!rstn_i)
		end_conv && !mode_wr && operation_select_o == 3'h2
		|=> !conv_done_n_o && operation_select_o == 3'h0 && result_valid_o)
		else $error("single conversion end wrong");
	cal_end_a: assert property (@(posedge clk_sys_i) // R20
		disable iff (!rstn_i)
		end_conv && !mode_wr && operation_select_o[2]
		|=> cal_done_o && !converting_o && operation_select_o == 3'h0)
		else $error("calibration did not return idle");
	len_load_a: assert property (@(posedge clk_sys_i) // R23
		disable iff (!rstn_i)
		mode_wr && reg_wdata_i[7:5] == 3'h2 && reg_addr_i[1] == 1'b0
		##1 !s_q.conv_time[0].offset_alternation_enable
		|-> s_q.count == 15'(s_q.conv_time[0].filter_length_word * 64
			+ 205))
		else $error("alternation off length wrong");
	clk_stop_a: assert property (@(posedge clk_sys_i) // R15
		disable iff (!rstn_i) clk_stopped && !mode_wr
		|=> $stable(s_q.count) && !result_valid_o)
		else $error("conversion ran with clock stopped");
	clamp_hi_a: assert property (@(posedge clk_sys_i) // R19
		disable iff (!rstn_i) end_conv && !mode_wr && s_q.mode.clamp
		&& over_range_i && !negative_i && !operation_select_o[2]
		|=> result_data_o == 24'hFFFFFF)
		else $error("clamp did not saturate");
	cont_next_a: assert property (@(posedge clk_sys_i) // R21
		disable iff (!rstn_i) end_conv && !mode_wr
		&& operation_select_o == 3'h1 && (&chan_enable_i)
		|=> active_chan_o != $past(active_chan_o) && converting_o)
		else $error("continuous did not switch channel");
	// Clamp low side, and the raw path when clamping is off.
	clamp_lo_a: assert property (@(posedge clk_sys_i) // R19
		disable iff (!rstn_i) end_conv && !mode_wr && s_q.mode.clamp
		&& over_range_i && negative_i && !operation_select_o[2]
		|=> result_data_o == 24'h000000)
		else $error("clamp did not floor");
	raw_data_a: assert property (@(posedge clk_sys_i) // R19
		disable iff (!rstn_i) end_conv && !mode_wr && !s_q.mode.clamp
		&& !operation_select_o[2]
		|=> result_data_o == $past(sample_i))
		else $error("raw result not stored");
	// Standby and the reserved code must start no conversion.
	standby_entry_a: assert property (@(posedge clk_sys_i) // R12
		disable iff (!rstn_i) mode_wr && reg_wdata_i[7:5] == 3'h3
		|=> standby_o && !converting_o)
		else $error("standby not entered");
	reserved_idle_a: assert property (@(posedge clk_sys_i) // R12
		disable iff (!rstn_i) mode_wr && reg_wdata_i[7:5] == 3'h5
		|=> !standby_o && !converting_o && !cal_done_o)
		else $error("reserved code did not idle");
	// The operation code and width bit of the mode register read back at its read offset.
	mode_read_a: assert property (@(posedge clk_sys_i) // R7
		disable iff (!rstn_i) reg_rd_i && reg_addr_i == MODE_RD_OFS
		|=> reg_rdata_o[7:5] == $past(operation_select_o)
		&& reg_rdata_o[1] == $past(wide_result_o))
		else $error("mode read-back wrong");
	// A single conversion on channel one loads the alternation-on length.
	len_alt_on_a: assert property (@(posedge clk_sys_i) // R3
		disable iff (!rstn_i)
		mode_wr && reg_wdata_i[7:5] == 3'h2 && reg_addr_i[1] == 1'b1
		##1 s_q.conv_time[1].offset_alternation_enable
		|-> s_q.count == 15'(s_q.conv_time[1].filter_length_word * 128
			+ 247))
		else $error("alternation on length wrong");
	// Calibrations report through their own pulse, not the done pin.
	cal_pin_a: assert property (@(posedge clk_sys_i) // R20
		disable iff (!rstn_i)
		end_conv && !mode_wr && operation_select_o[2]
		|=> conv_done_n_o == $past(conv_done_n_o))
		else $error("calibration moved done pin");

endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module host_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] rdata_i,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o
);
	// All strobes idle at time zero.
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// Data goes to its inverse after the strobe, so nothing stale lingers.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_sys_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	// mode read offset
	// Callers read the mode register through 38h only.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_sys_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule

// *** tb_adc_mode_and_timing_control.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for mode and timing control
// ----------------------------------------------------------------
module tb_adc_mode_and_timing_control;
	import adc_ctrl_pkg::*;
	logic        clk_sys_i, rstn_i, wr, rd, ext_src, over, neg;
	logic        done_n, st_clr, res_vld, res_chan, cal_done, conv;
	logic        act_chan, stby, osc_oe, clk_run, swd, cont_rd, wide;
	logic [7:0]  addr, wdata, rdata, v;
	logic [1:0]  chan_en;
	logic [2:0]  op;
	logic [23:0] sample, res;
	int          error_cnt, comparisons, n;
	logic [7:0]  cal_codes [3] = '{8'h80, 8'hC0, 8'hE0};

	adc_mode_and_timing_control adc_mode_and_timing_control_inst (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .chan_enable_i(chan_en),
		.ext_clock_source_i(ext_src), .sample_i(sample),
		.over_range_i(over), .negative_i(neg), .conv_done_n_o(done_n),
		.status_clear_o(st_clr), .result_valid_o(res_vld),
		.result_data_o(res), .result_chan_o(res_chan),
		.cal_done_o(cal_done), .converting_o(conv),
		.active_chan_o(act_chan), .operation_select_o(op),
		.standby_o(stby), .oscillator_drive_oe_o(osc_oe),
		.converter_clock_run_o(clk_run), .status_with_data_o(swd),
		.continuous_read_o(cont_rd), .wide_result_o(wide));
	host_model host_model_inst (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
		.wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Counts falling edges up to a pulse; a hang is cut short here.
	task automatic wait_for(input bit cal, output int cnt);
		cnt = 0;
		while ((cal ? cal_done : res_vld) !== 1'b1) begin
			@(negedge clk_sys_i);
			cnt++;
			if (cnt > 3000) begin
				error_cnt++;
				summarize();
			end
		end
	endtask
	// Reset values, read-back and an unmapped offset.
	task automatic regs();
		host_model_inst.rd(CONV_TIME_CH0_OFS, v);
		chk("ct0_reset", 8'h91, v);
		host_model_inst.rd(CONV_TIME_CH1_OFS, v);
		chk("ct1_reset", 8'h91, v);
		host_model_inst.rd(MODE_RD_OFS, v);
		chk("mode_reset", 8'h00, v);
		chk("idle_reset", 3'h0, op);
		host_model_inst.wr(CONV_TIME_CH0_OFS, 8'h03);
		host_model_inst.wr(CONV_TIME_CH1_OFS, 8'h82);
		host_model_inst.rd(CONV_TIME_CH0_OFS, v);
		chk("ct0_rw", 8'h03, v);
		host_model_inst.rd(CONV_TIME_CH1_OFS, v);
		chk("ct1_rw", 8'h82, v);
		host_model_inst.rd(8'h00, v);
		chk("unmapped", 8'h00, v);
		$display("register test done");
	endtask
	// One single conversion, judged on timing, channel and data.
	task automatic single(input logic [7:0] a, input logic [7:0] m,
		input int len, input logic [23:0] e);
		host_model_inst.wr(a, m);
		chk("status_clear", 1'b1, st_clr);
		chk("done_n_high", 1'b1, done_n);
		chk("op_running", 3'h2, op);
		chk("active_chan", a[1], act_chan);
		wait_for(1'b0, n);
		chk("conv_length", len, n);
		chk("done_n_low", 1'b0, done_n);
		chk("op_cleared", 3'h0, op);
		chk("result_chan", a[1], res_chan);
		chk("result_data", e, res);
		$display("single test done");
	endtask
	// Continuous with both channels: lengths carry the extra cycle.
	task automatic cont();
		chan_en = 2'h3;
		host_model_inst.wr(MODE_RD_OFS, 8'h20);
		wait_for(1'b0, n);
		chk("cont_len0", 399, n);
		chk("cont_chan0", 1'b0, res_chan);
		chk("raw_data", sample, res);
		@(negedge clk_sys_i);
		wait_for(1'b0, n);
		chk("cont_len1", 505, n + 1);
		chk("cont_chan1", 1'b1, res_chan);
		@(negedge clk_sys_i);
		wait_for(1'b0, n);
		chk("cont_len2", 399, n + 1);
		chk("cont_chan2", 1'b0, res_chan);
		$display("continuous test done");
	endtask
	// Mode bits, the remaining codes and the three calibrations.
	task automatic modes();
		host_model_inst.wr(MODE_RD_OFS, 8'h1F);
		repeat (6) @(negedge clk_sys_i);
		chk("idle_code", 3'h0, op);
		chk("osc_float", 1'b0, osc_oe);
		chk("clk_stop", 1'b0, clk_run);
		chk("dump_rd", 1'b1, swd);
		chk("cont_rd", 1'b1, cont_rd);
		chk("wide", 1'b1, wide);
		host_model_inst.rd(MODE_RD_OFS, v);
		chk("mode_rw", 8'h1F, v);
		// A crystal-clocked single conversion must stall, then resume.
		host_model_inst.wr(MODE_RD_OFS, 8'h50);
		repeat (500) @(negedge clk_sys_i);
		chk("stalled_op", 3'h2, op);
		chk("stalled_conv", 1'b0, conv);
		ext_src = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		chk("clk_ext_run", 1'b1, clk_run);
		chk("conv_resume", 1'b1, conv);
		host_model_inst.wr(MODE_RD_OFS, 8'h08);
		chk("dump", 1'b1, swd);
		chk("narrow", 1'b0, wide);
		chk("osc_drive", 1'b1, osc_oe);
		host_model_inst.wr(MODE_RD_OFS, 8'h60);
		chk("standby", 1'b1, stby);
		host_model_inst.wr(MODE_RD_OFS, 8'hA0);
		@(negedge clk_sys_i);
		chk("reserved", 1'b0, conv);
		foreach (cal_codes[i]) begin
			host_model_inst.wr(MODE_RD_OFS, cal_codes[i]);
			wait_for(1'b1, n);
			chk("cal_len", 398, n);
			@(negedge clk_sys_i);
			chk("cal_idle", 3'h0, op);
			chk("cal_done_n", 1'b1, done_n);
		end
		$display("mode test done");
	endtask

	// Free-running 25 MHz clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// Main sequence; a restarted mode must time from its own write.
	initial begin
		rstn_i = 1'b0;
		chan_en = 2'h1;
		ext_src = 1'b0;
		sample = 24'h123456;
		over = 1'b1;
		neg = 1'b1;
		error_cnt = 0;
		comparisons = 0;
		repeat (10) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		regs();
		single(MODE_RD_OFS, 8'h41, 398, 24'h000000);
		neg = 1'b0;
		single(MODE_WR_ALT_OFS, 8'h43, 504, 24'hFFFFFF);
		host_model_inst.wr(MODE_RD_OFS, 8'h40);
		repeat (20) @(negedge clk_sys_i);
		single(MODE_RD_OFS, 8'h41, 398, 24'hFFFFFF);
		cont();
		modes();
		summarize();
	end
endmodule
